// file: src/rou_unit.sv
`timescale 1ns/1ps
`include "rou_defs.svh"

module rou_unit (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          op_valid,
  input  wire logic [15:0]   instr,
  input  rou_pkg::rou_regs_t regs,
  output rou_pkg::rou_wr_t   wr_dst,
  output rou_pkg::rou_wr_t   wr_src,
  output logic               carry,
  output logic               overflow,
  output logic               done
);

  // ************************************************************
  // decode
  // ************************************************************
  function automatic rou_pkg::rou_word_t rou_pick(
    input rou_pkg::rou_regs_t r,
    input logic [2:0]         sel
  );
    if (sel == `ROU_SEL_NONE) begin
      rou_pick = `ROU_WORD_ZERO;
    end else begin
      rou_pick = r[sel];
    end
  endfunction : rou_pick

  rou_pkg::rou_dec_t  dec;
  rou_pkg::rou_word_t src_raw;
  rou_pkg::rou_word_t dst_raw;
  rou_pkg::rou_word_t dst_result;
  rou_pkg::rou_word_t src_result;
  logic               alu_carry;
  logic               alu_overflow;
  logic               take;
  logic               is_swap;

  assign take = op_valid &&
    (instr[`ROU_CLASS_MSB:`ROU_CLASS_LSB] == `ROU_CLASS_CODE);
  assign dec.add_select         = instr[`ROU_ADD_BIT];
  assign dec.carry_select       = instr[`ROU_CARRY_BIT];
  assign dec.add_constant_one   = instr[`ROU_INC_BIT];
  assign dec.complement_source  = instr[`ROU_CM1_BIT];
  assign dec.clear_destination  = instr[`ROU_CLD_BIT];
  assign dec.source_select      = instr[`ROU_SRC_MSB:`ROU_SRC_LSB];
  assign dec.destination_select = instr[`ROU_DST_MSB:`ROU_DST_LSB];

  assign src_raw = rou_pick(regs, dec.source_select);
  assign dst_raw = rou_pick(regs, dec.destination_select);
  assign is_swap = !dec.add_select &&
    ({dec.carry_select, dec.add_constant_one} == `ROU_OP_SWAP);

  rou_alu u_alu (
    .dec          (dec),
    .src_raw      (src_raw),
    .dst_raw      (dst_raw),
    .carry_in     (carry),
    .dst_result   (dst_result),
    .src_result   (src_result),
    .carry_out    (alu_carry),
    .overflow_out (alu_overflow)
  );

  // ************************************************************
  // results and indicators
  // ************************************************************
  rou_pkg::rou_wr_t wr_dst_r;
  rou_pkg::rou_wr_t wr_dst_nxt;
  rou_pkg::rou_wr_t wr_src_r;
  rou_pkg::rou_wr_t wr_src_nxt;
  logic             carry_r;
  logic             carry_nxt;
  logic             overflow_r;
  logic             overflow_nxt;
  logic             done_r;
  logic             done_nxt;
  logic             dst_none;

  assign dst_none = (dec.destination_select == `ROU_SEL_NONE);

  always_comb begin
    wr_dst_nxt      = '0;
    wr_src_nxt      = '0;
    carry_nxt       = carry_r;
    overflow_nxt    = overflow_r;
    done_nxt        = take;
    wr_dst_nxt.sel  = dec.destination_select;
    wr_dst_nxt.data = dst_result;
    wr_src_nxt.sel  = dec.source_select;
    wr_src_nxt.data = src_result;
    if (take) begin
      wr_dst_nxt.en = !dst_none;
      // on a same-register swap the destination write wins
      wr_src_nxt.en = is_swap && !dst_none &&
        (dec.source_select != `ROU_SEL_NONE) &&
        (dec.source_select != dec.destination_select);
      if (dec.add_select) begin
        if (dst_none) begin
          carry_nxt = `ROU_FLAG_RESET;
        end else begin
          carry_nxt    = alu_carry;
          overflow_nxt = alu_overflow;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_dst_r   <= '0;
      wr_src_r   <= '0;
      carry_r    <= `ROU_FLAG_RESET;
      overflow_r <= `ROU_FLAG_RESET;
      done_r     <= 1'b0;
    end else begin
      wr_dst_r   <= wr_dst_nxt;
      wr_src_r   <= wr_src_nxt;
      carry_r    <= carry_nxt;
      overflow_r <= overflow_nxt;
      done_r     <= done_nxt;
    end
  end

  assign wr_dst   = wr_dst_r;
  assign wr_src   = wr_src_r;
  assign carry    = carry_r;
  assign overflow = overflow_r;
  assign done     = done_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [4:0] mods;
  assign mods = {dec.add_select, dec.carry_select, dec.add_constant_one,
                 dec.complement_source, dec.clear_destination};

  chk_dst_write_sel: assert property (
    take && !dst_none |=> wr_dst_r.en &&
      wr_dst_r.sel == $past(dec.destination_select))
    else $error("destination write missing or misdirected");

  chk_dst_zero_nop: assert property (
    take && dst_none |=> !wr_dst_r.en && !wr_src_r.en)
    else $error("write seen with destination select zero");

  chk_dst_zero_carry: assert property (
    take && dst_none && dec.add_select |=> !carry_r)
    else $error("carry not cleared on add to no register");

  chk_src_zero_copy: assert property (
    take && !dst_none && mods == 5'h11 &&
      dec.source_select == `ROU_SEL_NONE |=> wr_dst_r.data == 16'h0000)
    else $error("zero source select did not give zero");

  chk_copy_same_reg: assert property (
    take && !dst_none && mods == 5'h11 &&
      dec.source_select == dec.destination_select
      |=> wr_dst_r.data == $past(dst_raw))
    else $error("cleared destination also cleared source");

  chk_complement_op: assert property (
    take && !dst_none && mods == 5'h13
      |=> wr_dst_r.data == ~$past(src_raw))
    else $error("complemented copy wrong");

  chk_add_carry_in: assert property (
    take && !dst_none && mods == 5'h18 |=> wr_dst_r.data ==
      $past(dst_raw + src_raw + 16'(carry_r)))
    else $error("add with carry wrong");

  chk_inc_no_carry: assert property (
    take && !dst_none && mods == 5'h1c |=> wr_dst_r.data ==
      $past(dst_raw + src_raw + `ROU_WORD_ONE))
    else $error("add one with carry select wrong");

  chk_sub_result: assert property (
    take && !dst_none && mods == 5'h16 |=> wr_dst_r.data ==
      $past(dst_raw - src_raw))
    else $error("subtraction wrong");

  chk_logic_flags: assert property (
    take && !dec.add_select |=> $stable(carry_r) && $stable(overflow_r))
    else $error("logical operation changed indicators");

  chk_and_result: assert property (
    take && !dst_none && mods == 5'h04 |=> wr_dst_r.data ==
      $past(dst_raw & src_raw))
    else $error("logical and wrong");

  chk_swap_pair: assert property (
    take && !dst_none && mods == 5'h00 &&
      dec.source_select != `ROU_SEL_NONE &&
      dec.source_select != dec.destination_select
      |=> wr_src_r.en && wr_src_r.data == $past(dst_raw) &&
          wr_dst_r.data == $past(src_raw))
    else $error("swap did not exchange");

  chk_swap_clear: assert property (
    take && !dst_none && mods == 5'h01 |=> wr_src_r.data == 16'h0000)
    else $error("swap with clear left source nonzero");

endmodule : rou_unit

// file: src/rou_defs.svh
`ifndef ROU_DEFS_SVH
`define ROU_DEFS_SVH

// ************************************************************
// instruction field positions
// ************************************************************
`define ROU_DST_LSB      0
`define ROU_DST_MSB      2
`define ROU_SRC_LSB      3
`define ROU_SRC_MSB      5
`define ROU_CLD_BIT      6
`define ROU_CM1_BIT      7
`define ROU_INC_BIT      8
`define ROU_CARRY_BIT    9
`define ROU_ADD_BIT      10
`define ROU_CLASS_LSB    11
`define ROU_CLASS_MSB    15

// ************************************************************
// codes and values
// ************************************************************
`define ROU_CLASS_CODE   5'h19
`define ROU_SEL_NONE     3'h0
`define ROU_OP_SWAP      2'h0
`define ROU_OP_AND       2'h1
`define ROU_OP_XOR       2'h2
`define ROU_OP_OR        2'h3
`define ROU_FLAG_RESET   1'b0
`define ROU_WORD_ZERO    16'h0000
`define ROU_WORD_ONE     16'h0001

`endif

// file: src/rou_pkg.sv
package rou_pkg;

  typedef logic [15:0] rou_word_t;

  // general registers, index 1..7; code 0 means no register
  typedef rou_word_t [7:1] rou_regs_t;

  typedef struct packed {
    logic       add_select;
    logic       carry_select;
    logic       add_constant_one;
    logic       complement_source;
    logic       clear_destination;
    logic [2:0] source_select;
    logic [2:0] destination_select;
  } rou_dec_t;

  typedef struct packed {
    logic       en;
    logic [2:0] sel;
    rou_word_t  data;
  } rou_wr_t;

endpackage : rou_pkg

// file: src/rou_alu.sv
`timescale 1ns/1ps
`include "rou_defs.svh"

module rou_alu (
  input  rou_pkg::rou_dec_t  dec,
  input  rou_pkg::rou_word_t src_raw,
  input  rou_pkg::rou_word_t dst_raw,
  input  wire logic          carry_in,
  output rou_pkg::rou_word_t dst_result,
  output rou_pkg::rou_word_t src_result,
  output logic               carry_out,
  output logic               overflow_out
);

  rou_pkg::rou_word_t src_op;
  rou_pkg::rou_word_t dst_op;
  logic [16:0]        sum;
  logic               cin;

  always_comb begin
    // source reads the register before any clearing takes effect
    src_op = dec.complement_source ? ~src_raw : src_raw;
    dst_op = dec.clear_destination ? `ROU_WORD_ZERO : dst_raw;
    // add-one wins over old carry when both are requested
    cin = dec.add_constant_one |
          (dec.carry_select & carry_in);
    sum = {1'b0, dst_op} + {1'b0, src_op} + {16'h0000, cin};
    carry_out    = sum[16];
    overflow_out = (dst_op[15] == src_op[15]) &&
                   (sum[15] != dst_op[15]);
    src_result = dst_op;
    if (dec.add_select) begin
      dst_result = sum[15:0];
    end else begin
      case ({dec.carry_select, dec.add_constant_one})
        `ROU_OP_SWAP: dst_result = src_op;
        `ROU_OP_AND:  dst_result = dst_op & src_op;
        `ROU_OP_XOR:  dst_result = dst_op ^ src_op;
        `ROU_OP_OR:   dst_result = dst_op | src_op;
        default:      dst_result = `ROU_WORD_ZERO;
      endcase
    end
  end

endmodule : rou_alu

// file: verification/tb.sv
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  fails++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end

module tb;
  // ************************************************************
  // signals
  // ************************************************************
  logic               mclk;
  logic               reset;
  logic               op_valid;
  logic [15:0]        instr;
  rou_pkg::rou_regs_t regs;
  rou_pkg::rou_wr_t   wr_dst;
  rou_pkg::rou_wr_t   wr_src;
  logic               carry;
  logic               overflow;
  logic               done;
  rou_pkg::rou_regs_t regs_m;
  logic               carry_m;
  logic               ov_m;
  int                 fails;
  int                 total_checks;

  rou_unit i_dut (
    .mclk     (mclk),
    .reset    (reset),
    .op_valid (op_valid),
    .instr    (instr),
    .regs     (regs),
    .wr_dst   (wr_dst),
    .wr_src   (wr_src),
    .carry    (carry),
    .overflow (overflow),
    .done     (done)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // ************************************************************
  // one instruction with reference model and checks
  // ************************************************************
  task automatic exec(input logic [15:0] ins);
    rou_pkg::rou_word_t s;
    rou_pkg::rou_word_t d;
    rou_pkg::rou_word_t res;
    logic [16:0]        sum;
    logic [2:0]         ss;
    logic [2:0]         ds;
    logic               e_den;
    logic               e_sen;
    logic               e_c;
    logic               e_v;
    ss = ins[5:3];
    ds = ins[2:0];
    s = (ss == 3'h0) ? 16'h0000 : regs_m[ss];
    d = (ds == 3'h0) ? 16'h0000 : regs_m[ds];
    if (ins[6]) d = 16'h0000;
    if (ins[7]) s = ~s;
    e_c = carry_m;
    e_v = ov_m;
    e_sen = 1'b0;
    e_den = (ds != 3'h0);
    if (ins[10]) begin
      sum = {1'b0, d} + {1'b0, s}
          + (ins[8] ? 17'h00001 : (ins[9] ? {16'h0000, carry_m} : 17'h0));
      res = sum[15:0];
      e_c = (ds == 3'h0) ? 1'b0 : sum[16];
      if (ds != 3'h0) e_v = (d[15] == s[15]) && (res[15] != d[15]);
    end else begin
      case (ins[9:8])
        2'h0: begin
          res = s;
          e_sen = (ss != 3'h0) && (ss != ds) && (ds != 3'h0);
        end
        2'h1: res = d & s;
        2'h2: res = d ^ s;
        default: res = d | s;
      endcase
    end
    @(posedge mclk);
    op_valid <= 1'b1;
    instr    <= ins;
    regs     <= regs_m;
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    `CHK("done", 1'b1, done)
    `CHK("dst_en", e_den, wr_dst.en)
    if (e_den) begin
      `CHK("dst_sel", ds, wr_dst.sel)
      `CHK("dst_data", res, wr_dst.data)
    end
    `CHK("src_en", e_sen, wr_src.en)
    if (e_sen) begin
      `CHK("src_sel", ss, wr_src.sel)
      `CHK("src_data", d, wr_src.data)
    end
    `CHK("carry", e_c, carry)
    `CHK("overflow", e_v, overflow)
    if (e_sen) regs_m[ss] = d;
    if (e_den) regs_m[ds] = res;
    carry_m = e_c;
    ov_m = e_v;
    @(posedge mclk);
    #1;
    `CHK("done_pulse", 1'b0, done)
  endtask : exec

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    op_valid = 1'b0;
    instr = 16'h0000;
    regs_m = {16'h0f0f, 16'ha5a5, 16'h1234, 16'h0001,
              16'hffff, 16'h8000, 16'h7fff};
    regs = regs_m;
    carry_m = 1'b0;
    ov_m = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    #1;
    `CHK("rst_carry", 1'b0, carry)
    `CHK("rst_ovf", 1'b0, overflow)
    exec(16'hcc00 | 16'h0008 | 16'h0002);
    exec(16'hcc00 | 16'h0020 | 16'h0003);
    exec(16'hcd80 | 16'h0010 | 16'h0005);
    exec(16'hcc40 | 16'h0004);
    // every modifier combination over rotating register selects
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 32; k++) begin
        exec({5'h19, k[4:0], 3'((k + p) % 8),
              3'((k * 5 + p * 3) % 8)});
      end
    end
    // wrong class code must be ignored
    @(posedge mclk);
    op_valid <= 1'b1;
    instr    <= 16'hc40a;
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    `CHK("ignored_done", 1'b0, done)
    `CHK("ignored_wr", 1'b0, wr_dst.en)
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    finish_test();
  end
endmodule : tb
